// ==== hdl/msi_defs.svh ====
`ifndef MSI_DEFS_SVH
`define MSI_DEFS_SVH
// register word addresses (byte address = index * 4)
`define MSI_ADDR_TXQP 6'h07
`define MSI_ADDR_RSR 6'h08
`define MSI_ADDR_ISR 6'h09
`define MSI_ADDR_IER 6'h0a
`define MSI_ADDR_IDR 6'h0b
`define MSI_ADDR_IMR 6'h0c
// receive status field positions
`define MSI_RS_NOBUF 0
`define MSI_RS_STORED 1
`define MSI_RS_OVERRUN 2
// interrupt bit positions
`define MSI_IRQ_MGMT 0
`define MSI_IRQ_RX_DONE 1
`define MSI_IRQ_RX_USED 2
`define MSI_IRQ_TX_USED 3
`define MSI_IRQ_TX_UNDER 4
`define MSI_IRQ_RETRY 5
`define MSI_IRQ_TX_EXHAUST 6
`define MSI_IRQ_TX_DONE 7
`define MSI_IRQ_RX_OVERRUN 10
`define MSI_IRQ_BUS_ERR 11
`define MSI_IRQ_PAUSE_RX 12
`define MSI_IRQ_PAUSE_ZERO 13
// implemented interrupt bits and reset values
`define MSI_IRQ_IMPL 14'h3cff
`define MSI_MASK_RESET 14'h3cff
`define MSI_TXQP_RESET 32'h0000_0000
`endif

// ==== hdl/msi_pkg.sv ====
package msi_pkg;
	typedef logic [13:0] msi_irq_t;
	typedef enum logic [1:0] {
		MSI_IDLE = 2'b00,
		MSI_ANSWER = 2'b01
	} msi_bus_state_t;
endpackage : msi_pkg

// ==== hdl/msi_top.sv ====
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "msi_defs.svh"
module msi_top (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// event strobes from dma, management and pause logic
	input wire logic ev_mgmt_done,
	input wire logic ev_rx_stored,
	input wire logic ev_rx_used_bit,
	input wire logic ev_rx_fetch_fail,
	input wire logic ev_rx_overrun,
	input wire logic ev_tx_used_bit,
	input wire logic ev_tx_underrun,
	input wire logic ev_retry_limit,
	input wire logic ev_tx_exhausted,
	input wire logic ev_tx_complete,
	input wire logic ev_bus_error,
	input wire logic ev_pause_rx,
	input wire logic ev_pause_zero,
	// tx dma pointer interface
	input wire logic [31:0] tx_frame_start,
	input wire logic tx_frame_start_valid,
	output logic [31:0] tx_queue_pointer,
	output logic tx_queue_load,
	// rx dma retry request
	input wire logic rx_frame_start,
	output logic rx_pointer_reread,
	// interrupt
	output logic irq
);

////////////////////////////////////////////////////////////////////////
// reset release
logic rst_meta;
logic rst_n;
always_ff @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		rst_meta <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta <= 1'b1;
		rst_n <= rst_meta;
	end
end

////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, answer on second edge
msi_pkg::msi_bus_state_t bus_state;
msi_pkg::msi_bus_state_t next_bus_state;
wire bus_req = avs_read | avs_write;
wire bus_take = (bus_state == msi_pkg::MSI_ANSWER) & bus_req;
wire wr_take = bus_take & avs_write;
// read side effects at the capture edge, so no event slips between capture and answer
wire rd_take = (bus_state == msi_pkg::MSI_IDLE) & avs_read;
wire lo_lane = avs_byteenable[0];
wire hi_lane = avs_byteenable[1];
wire hit_txqp = avs_address == `MSI_ADDR_TXQP;
wire hit_rsr = avs_address == `MSI_ADDR_RSR;
wire hit_isr = avs_address == `MSI_ADDR_ISR;
wire hit_ier = avs_address == `MSI_ADDR_IER;
wire hit_idr = avs_address == `MSI_ADDR_IDR;
wire hit_imr = avs_address == `MSI_ADDR_IMR;

function automatic msi_pkg::msi_irq_t lane_bits(input logic [31:0] d, input logic b0, input logic b1);
	lane_bits = {d[13:8] & {6{b1}}, d[7:0] & {8{b0}}} & `MSI_IRQ_IMPL;
endfunction : lane_bits

always_comb begin
	case (bus_state)
		msi_pkg::MSI_IDLE: next_bus_state = bus_req ? msi_pkg::MSI_ANSWER : msi_pkg::MSI_IDLE;
		msi_pkg::MSI_ANSWER: next_bus_state = msi_pkg::MSI_IDLE;
		default: next_bus_state = msi_pkg::MSI_IDLE;
	endcase
end

always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		bus_state <= msi_pkg::MSI_IDLE;
	end else begin
		bus_state <= next_bus_state;
	end
end

wire next_wait = ~(next_bus_state == msi_pkg::MSI_ANSWER);
always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		avs_waitrequest <= 1'b1;
	end else begin
		avs_waitrequest <= next_wait;
	end
end

////////////////////////////////////////////////////////////////////////
// transmit queue pointer
wire txqp_wr = wr_take & hit_txqp;
logic [31:0] next_txqp;
assign next_txqp = txqp_wr ? avs_writedata : tx_frame_start;
always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		tx_queue_pointer <= `MSI_TXQP_RESET;
		tx_queue_load <= 1'b0;
	end else begin
		if (txqp_wr | tx_frame_start_valid) begin
			tx_queue_pointer <= next_txqp;
		end
		tx_queue_load <= txqp_wr;
	end
end

////////////////////////////////////////////////////////////////////////
// receive status, write one to clear, set wins
logic [2:0] receive_status;
logic rx_retry_pending;
wire [2:0] rs_set = {ev_rx_overrun, ev_rx_stored, ev_rx_fetch_fail};
wire [2:0] rs_clr = (wr_take & hit_rsr & lo_lane) ? avs_writedata[2:0] : 3'h0;
always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		receive_status <= 3'h0;
	end else begin
		receive_status <= rs_set | (receive_status & ~rs_clr);
	end
end

wire next_retry = ev_rx_fetch_fail | (rx_retry_pending & ~ev_rx_stored);
always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		rx_retry_pending <= 1'b0;
		rx_pointer_reread <= 1'b0;
	end else begin
		rx_retry_pending <= next_retry;
		rx_pointer_reread <= rx_retry_pending & rx_frame_start;
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt status, mask and output
msi_pkg::msi_irq_t interrupt_status;
msi_pkg::msi_irq_t interrupt_mask;
msi_pkg::msi_irq_t irq_set;
assign irq_set = {
	ev_pause_zero,
	ev_pause_rx,
	ev_bus_error,
	ev_rx_overrun,
	2'h0,
	ev_tx_complete,
	ev_tx_exhausted,
	ev_retry_limit,
	ev_tx_underrun | txqp_wr,
	ev_tx_used_bit,
	ev_rx_used_bit,
	ev_rx_stored,
	ev_mgmt_done
};

wire isr_rd = rd_take & hit_isr;
wire msi_pkg::msi_irq_t isr_keep = isr_rd ? 14'h0000 : interrupt_status;
wire msi_pkg::msi_irq_t next_isr = irq_set | isr_keep;
wire msi_pkg::msi_irq_t en_bits = (wr_take & hit_ier) ? lane_bits(avs_writedata, lo_lane, hi_lane) : 14'h0000;
wire msi_pkg::msi_irq_t dis_bits = (wr_take & hit_idr) ? lane_bits(avs_writedata, lo_lane, hi_lane) : 14'h0000;
wire msi_pkg::msi_irq_t next_mask = (interrupt_mask & ~en_bits) | dis_bits;
wire next_irq = |(next_isr & ~next_mask);

always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		interrupt_status <= 14'h0000;
		interrupt_mask <= `MSI_MASK_RESET;
		irq <= 1'b0;
	end else begin
		interrupt_status <= next_isr;
		interrupt_mask <= next_mask;
		irq <= next_irq;
	end
end

////////////////////////////////////////////////////////////////////////
// read data
logic [31:0] rd_mux;
always_comb begin
	rd_mux = 32'h0000_0000;
	if (hit_txqp) begin
		rd_mux = tx_queue_pointer;
	end else if (hit_rsr) begin
		rd_mux = {29'h0, receive_status};
	end else if (hit_isr) begin
		rd_mux = {18'h0, interrupt_status};
	end else if (hit_imr) begin
		rd_mux = {18'h0, interrupt_mask};
	end
end

always_ff @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		avs_readdata <= 32'h0000_0000;
	end else if (rd_take) begin
		avs_readdata <= rd_mux;
	end
end

////////////////////////////////////////////////////////////////////////
// checks
// mask register
mask_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_ier && lo_lane && avs_writedata[0]) |=> !interrupt_mask[0])
	else $error("enable write did not unmask bit 0");

mask_disable_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_idr && hi_lane && avs_writedata[13]) |=> interrupt_mask[13])
	else $error("disable write did not mask bit 13");

enable_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_ier && hi_lane && avs_writedata[13]) |=> !interrupt_mask[13])
	else $error("enable write did not unmask bit 13");

disable_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_idr && lo_lane && avs_writedata[0]) |=> interrupt_mask[0])
	else $error("disable write did not mask bit 0");

mask_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	!(wr_take && (hit_ier || hit_idr)) |=> $stable(interrupt_mask))
	else $error("mask changed without write");

mask_lane_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_ier && !lo_lane) |=> interrupt_mask[7:0] == $past(interrupt_mask[7:0]))
	else $error("disabled lane changed the mask");

mask_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	interrupt_mask[9:8] == 2'h0)
	else $error("unused mask bits set");

mask_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(rd_take && hit_imr) |=> avs_readdata == {18'h0, $past(interrupt_mask)})
	else $error("mask read data wrong");

// interrupt status register
isr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(isr_rd && irq_set == 14'h0000) |=> interrupt_status == 14'h0000)
	else $error("status not cleared by read");

isr_set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	isr_rd |=> interrupt_status == $past(irq_set))
	else $error("event lost at status read");

isr_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	!isr_rd |=> (interrupt_status & $past(interrupt_status)) == $past(interrupt_status))
	else $error("status bit dropped without read");

isr_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	interrupt_status[9:8] == 2'h0)
	else $error("unused status bits set");

isr_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(rd_take && hit_isr) |=> avs_readdata == {18'h0, $past(interrupt_status)})
	else $error("status read data wrong");

// per source set
mgmt_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_mgmt_done |=> interrupt_status[`MSI_IRQ_MGMT])
	else $error("management done bit not set");

rx_done_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_rx_stored |=> interrupt_status[`MSI_IRQ_RX_DONE])
	else $error("receive complete bit not set");

rx_used_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_rx_used_bit |=> interrupt_status[`MSI_IRQ_RX_USED])
	else $error("receive used bit not set");

tx_used_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_tx_used_bit |=> interrupt_status[`MSI_IRQ_TX_USED])
	else $error("transmit used bit not set");

tx_under_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_tx_underrun |=> interrupt_status[`MSI_IRQ_TX_UNDER])
	else $error("underrun bit not set");

retry_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_retry_limit |=> interrupt_status[`MSI_IRQ_RETRY])
	else $error("retry limit bit not set");

tx_exhaust_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_tx_exhausted |=> interrupt_status[`MSI_IRQ_TX_EXHAUST])
	else $error("exhausted bit not set");

tx_done_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_tx_complete |=> interrupt_status[`MSI_IRQ_TX_DONE])
	else $error("transmit complete bit not set");

bus_err_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_bus_error |=> interrupt_status[`MSI_IRQ_BUS_ERR])
	else $error("bus error bit not set");

pause_rx_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_pause_rx |=> interrupt_status[`MSI_IRQ_PAUSE_RX])
	else $error("pause received bit not set");

pause_zero_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_pause_zero |=> interrupt_status[`MSI_IRQ_PAUSE_ZERO])
	else $error("pause zero bit not set");

ovr_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_rx_overrun |=> (interrupt_status[`MSI_IRQ_RX_OVERRUN] && receive_status[`MSI_RS_OVERRUN]))
	else $error("overrun bits not both set");

// receive status
rsr_set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	ev_rx_fetch_fail |=> receive_status[`MSI_RS_NOBUF])
	else $error("buffer unavailable flag lost");

rsr_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(receive_status[`MSI_RS_STORED] && !(wr_take && hit_rsr)) |=> receive_status[`MSI_RS_STORED])
	else $error("frame stored flag dropped");

rs_no_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_rsr) |=> (receive_status & ~$past(receive_status) & ~$past(rs_set)) == 3'h0)
	else $error("status write set a flag");

rs_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_rsr && lo_lane && avs_writedata[1] && !ev_rx_stored) |=> !receive_status[`MSI_RS_STORED])
	else $error("frame stored flag not cleared");

nobuf_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_rsr && lo_lane && avs_writedata[0] && !ev_rx_fetch_fail) |=> !receive_status[`MSI_RS_NOBUF])
	else $error("buffer unavailable flag not cleared");

ovr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(wr_take && hit_rsr && lo_lane && avs_writedata[2] && !ev_rx_overrun) |=> !receive_status[`MSI_RS_OVERRUN])
	else $error("overrun flag not cleared");

// pointer, retry and output
txqp_tx_underrun_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	txqp_wr |=> (interrupt_status[`MSI_IRQ_TX_UNDER] && tx_queue_pointer == $past(avs_writedata)))
	else $error("pointer write effects missing");

txqp_dma_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(tx_frame_start_valid && !txqp_wr) |=> tx_queue_pointer == $past(tx_frame_start))
	else $error("pointer not loaded from dma");

txqp_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	txqp_wr |=> tx_queue_load)
	else $error("load pulse missing");

load_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	!txqp_wr |=> !tx_queue_load)
	else $error("load pulse without write");

irq_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	irq == |(interrupt_status & ~interrupt_mask))
	else $error("interrupt output mismatch");

reread_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(rx_retry_pending && rx_frame_start) |=> rx_pointer_reread)
	else $error("pointer reread missing");

reread_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(!rx_retry_pending || !rx_frame_start) |=> !rx_pointer_reread)
	else $error("reread without pending failure");

retry_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
	(ev_rx_stored && !ev_rx_fetch_fail) |=> !rx_retry_pending)
	else $error("retry pending not cleared");

endmodule : msi_top
`default_nettype wire

// ==== verification/msi_top_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "msi_defs.svh"
module msi_top_bench;
	// stimulus and observed signals
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [13:0] ev = 14'h0000;
	logic [31:0] tx_frame_start = 32'h0000_0000;
	logic tx_frame_start_valid = 1'b0;
	logic [31:0] tx_queue_pointer;
	logic tx_queue_load;
	logic rx_pointer_reread;
	logic irq;
	int failures = 0, n_checks = 0, n_load = 0, n_reread = 0;
	msi_pkg::msi_irq_t exp_mask = `MSI_MASK_RESET;
	logic [2:0] exp_rsr = 3'h0;
	logic [31:0] q, p;
	logic [13:0] v;
	////////////////////////////////////////////////////////////////
	msi_top dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ev_mgmt_done(ev[0]), .ev_rx_stored(ev[1]), .ev_rx_used_bit(ev[2]), .ev_tx_used_bit(ev[3]),
		.ev_tx_underrun(ev[4]), .ev_retry_limit(ev[5]), .ev_tx_exhausted(ev[6]), .ev_tx_complete(ev[7]),
		.ev_rx_fetch_fail(ev[8]), .rx_frame_start(ev[9]), .ev_rx_overrun(ev[10]), .ev_bus_error(ev[11]),
		.ev_pause_rx(ev[12]), .ev_pause_zero(ev[13]), .tx_frame_start(tx_frame_start),
		.tx_frame_start_valid(tx_frame_start_valid), .tx_queue_pointer(tx_queue_pointer),
		.tx_queue_load(tx_queue_load), .rx_pointer_reread(rx_pointer_reread), .irq(irq)
	);
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// pulse counters
	always @(posedge clk_sys) begin
		if (tx_queue_load === 1'b1) n_load++;
		if (rx_pointer_reread === 1'b1) n_reread++;
	end
	////////////////////////////////////////////////////////////////
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task check_bit(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask : check_bit
	// one avalon transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		avs_write <= w;
		avs_read <= ~w;
		avs_address <= a;
		avs_writedata <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 64);
		if (avs_waitrequest !== 1'b0) failures++;
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask : wr
	task rd_check(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd_check
	task pulse(input logic [13:0] x);
		ev <= x;
		@(posedge clk_sys);
		ev <= 14'h0000;
		@(posedge clk_sys);
	endtask : pulse
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		failures++;
		complete_run();
	end
	initial begin
		void'($urandom(76477));
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd_check(`MSI_ADDR_IMR, {18'h0, `MSI_MASK_RESET});
		rd_check(`MSI_ADDR_ISR, 32'h0);
		rd_check(`MSI_ADDR_RSR, 32'h0);
		rd_check(`MSI_ADDR_TXQP, `MSI_TXQP_RESET);
		rd_check(6'h3f, 32'h0);
		check_bit(irq, 1'b0);
		$display("test reset done");
		// events against mask, status and receive flags
		for (int i = 0; i < 24; i++) begin
			v = (i == 0) ? 14'h3dff : 14'($urandom) & 14'h3dff;
			p = $urandom;
			wr(`MSI_ADDR_IER, p);
			exp_mask = exp_mask & ~(p[13:0] & `MSI_IRQ_IMPL);
			p = $urandom & $urandom;
			wr(`MSI_ADDR_IDR, p);
			exp_mask = exp_mask | (p[13:0] & `MSI_IRQ_IMPL);
			rd_check(`MSI_ADDR_IMR, {18'h0, exp_mask});
			pulse(v);
			exp_rsr = exp_rsr | {v[10], v[1], v[8]};
			check_bit(irq, |(v & ~exp_mask & `MSI_IRQ_IMPL));
			rd_check(`MSI_ADDR_ISR, {18'h0, v & `MSI_IRQ_IMPL});
			rd_check(`MSI_ADDR_ISR, 32'h0);
			check_bit(irq, 1'b0);
			rd_check(`MSI_ADDR_RSR, {29'h0, exp_rsr});
			p = $urandom;
			wr(`MSI_ADDR_RSR, p);
			exp_rsr = exp_rsr & ~p[2:0];
		end
		avs_byteenable <= 4'h1;
		wr(`MSI_ADDR_IDR, 32'h0000_3cff);
		exp_mask = exp_mask | 14'h00ff;
		avs_byteenable <= 4'hf;
		rd_check(`MSI_ADDR_IMR, {18'h0, exp_mask});
		wr(`MSI_ADDR_ISR, 32'hffff_ffff);
		rd_check(`MSI_ADDR_ISR, 32'h0);
		$display("test events done");
		// transmit queue pointer
		for (int i = 0; i < 4; i++) begin
			p = $urandom & 32'hffff_fff8;
			wr(`MSI_ADDR_TXQP, p);
			rd_check(`MSI_ADDR_TXQP, p);
			check(tx_queue_pointer, p);
			check(n_load, i + 1);
			rd_check(`MSI_ADDR_ISR, 32'h0000_0010);
			tx_frame_start <= $urandom;
			tx_frame_start_valid <= 1'b1;
			@(posedge clk_sys);
			tx_frame_start_valid <= 1'b0;
			@(posedge clk_sys);
			rd_check(`MSI_ADDR_TXQP, tx_frame_start);
		end
		$display("test pointer done");
		// reread after a failed fetch, until a frame is stored
		pulse(14'h0100);
		pulse(14'h0200);
		pulse(14'h0200);
		pulse(14'h0002);
		pulse(14'h0200);
		exp_rsr = exp_rsr | 3'h3;
		rd_check(`MSI_ADDR_RSR, {29'h0, exp_rsr});
		check(n_reread, 2);
		$display("test reread done");
		complete_run();
	end
endmodule : msi_top_bench
`default_nettype wire
